// File: hdl/plrs_pkg.sv
// Package with the counts and state encoding of the lock and reset stretcher.
package plrs_pkg;

  // Primary output cycles that the reset/lock output is held low after a request or lock.
  localparam int unsigned STRETCH_CYCLES = 1024;
  // The same interval expressed in reference input periods.
  localparam int unsigned STRETCH_REF_CYCLES = 512;
  // Width of the stretch counter.
  localparam int unsigned COUNT_W = 11;
  // Least low time of the reset request while locked, in ns.
  localparam int unsigned REQ_MIN_LOW_NS = 10;
  // Clock period in ns.
  localparam int unsigned CLOCK_PERIOD_NS = 4;
  // Least low time rounded up to whole clock cycles.
  localparam int unsigned REQ_MIN_LOW_CYCLES = (REQ_MIN_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Output state, Gray coded along unlocked, hold, count, released.
  typedef enum logic [1:0] {
    PLRS_WAIT  = 2'b00,
    PLRS_HOLD  = 2'b01,
    PLRS_COUNT = 2'b11,
    PLRS_IDLE  = 2'b10
  } plrs_state_t;

endpackage

// File: hdl/plrs_stretcher.sv
// Reset-pulse stretcher and lock indicator driving an open-drain active-low reset output.
`timescale 1ns/1ps
`default_nettype none

module plrs_stretcher
  import plrs_pkg::*;
#(
  parameter int unsigned STRETCH = STRETCH_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic q_tick,
  input  wire logic pll_locked,
  input  wire logic reset_req_n,
  output var  logic reset_out_oe,
  output var  logic reset_out_o,
  output var  logic lock_released
);

  // Two-stage synchronisers for the asynchronous request pin and the lock level.
  logic       req_s1;
  logic       req_s2;
  logic       lock_s1;
  logic       lock_s2;
  logic       req_prev;

  // The request stages reset to the idle high level of the pin, so no false rising edge follows reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      req_s1   <= 1'b1;
      req_s2   <= 1'b1;
      lock_s1  <= 1'b0;
      lock_s2  <= 1'b0;
      req_prev <= 1'b1;
    end else begin
      req_s1   <= reset_req_n;
      req_s2   <= req_s1;
      lock_s1  <= pll_locked;
      lock_s2  <= lock_s1;
      req_prev <= req_s2;
    end
  end

  logic req_rise;
  assign req_rise = req_s2 && !req_prev;

  plrs_state_t          state;
  plrs_state_t          next_state;
  logic [COUNT_W-1:0]   count;
  logic [COUNT_W-1:0]   next_count;
  logic                 next_oe;

  // The counter only sees primary-output ticks, so the clocks themselves are never gated here.
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      PLRS_WAIT: begin
        // Output held low until lock; an early low request keeps it there.
        if (lock_s2 && req_s2) begin
          next_state = PLRS_COUNT;
          next_count = '0;
        end else if (lock_s2) begin
          next_state = PLRS_HOLD;
        end
      end
      PLRS_HOLD: begin
        // Request still low: keep the output low, counter parked at zero.
        next_count = '0;
        if (req_s2) begin
          next_state = PLRS_COUNT;
        end
      end
      PLRS_COUNT: begin
        if (!req_s2) begin
          next_state = PLRS_HOLD;
          next_count = '0;
        end else if (req_rise) begin
          next_count = '0;
        end else if (q_tick) begin
          if (count == COUNT_W'(STRETCH - 1)) begin
            next_state = PLRS_IDLE;
            next_count = '0;
          end else begin
            next_count = count + COUNT_W'(1);
          end
        end
      end
      PLRS_IDLE: begin
        // Released; a low request after lock starts a new reset pulse.
        if (!req_s2) begin
          next_state = PLRS_HOLD;
        end else if (!lock_s2) begin
          next_state = PLRS_WAIT;
        end
      end
      default: begin
        next_state = PLRS_WAIT;
        next_count = '0;
      end
    endcase
    next_oe = (next_state != PLRS_IDLE);
  end

  // Registers of the state, count and the open-drain enable.
  always_ff @(posedge clock) begin
    if (rst) begin
      state         <= PLRS_WAIT;
      count         <= '0;
      reset_out_oe  <= 1'b1;
      lock_released <= 1'b0;
    end else begin
      state         <= next_state;
      count         <= next_count;
      reset_out_oe  <= next_oe;
      lock_released <= !next_oe;
    end
  end

  // Open-drain: the pin only ever drives low.
  always_ff @(posedge clock) begin
    reset_out_o <= 1'b0;
  end

  // Assertions.
  chk_release_needs_full: assert property (@(posedge clock) disable iff (rst)
    $rose(lock_released) |-> $past(state) == PLRS_COUNT && $past(q_tick) &&
      $past(count) == COUNT_W'(STRETCH - 1))
    else $error("Output released without a completed interval.");
  chk_low_req_drives: assert property (@(posedge clock) disable iff (rst)
    (state == PLRS_IDLE && !req_s2) |=> reset_out_oe)
    else $error("Low request did not drive the output.");
  chk_hold_while_low: assert property (@(posedge clock) disable iff (rst)
    (!req_s2 && state != PLRS_WAIT) |=> state == PLRS_HOLD)
    else $error("Output not held while request low.");
  chk_restart_zero: assert property (@(posedge clock) disable iff (rst)
    (state == PLRS_HOLD) |-> count == '0)
    else $error("Counter not parked while request low.");
  chk_unlocked_low: assert property (@(posedge clock) disable iff (rst)
    (state == PLRS_WAIT) |=> reset_out_oe)
    else $error("Output released before lock.");
  chk_count_step: assert property (@(posedge clock) disable iff (rst)
    (state == PLRS_COUNT && req_s2 && !req_rise && q_tick && count < COUNT_W'(STRETCH - 1))
      |=> count == $past(count) + COUNT_W'(1))
    else $error("Counter did not advance on a tick.");
  chk_drive_low_only: assert property (@(posedge clock) disable iff (rst)
    ##1 !reset_out_o)
    else $error("Open-drain output drove high.");
  chk_oe_matches: assert property (@(posedge clock) disable iff (rst)
    reset_out_oe == !lock_released)
    else $error("Enable and release flag disagree.");

  // Named steps of a reset pulse: a low request seen while released, then the output driven.
  sequence seq_req_low_released;
    state == PLRS_IDLE && !req_s2;
  endsequence

  sequence seq_driven_hold;
    reset_out_oe && state == PLRS_HOLD;
  endsequence

  // Steps of a completed interval: the last counted tick, then the released output.
  sequence seq_last_tick;
    state == PLRS_COUNT && req_s2 && !req_rise && q_tick && count == COUNT_W'(STRETCH - 1);
  endsequence

  sequence seq_released;
    state == PLRS_IDLE && !reset_out_oe && lock_released;
  endsequence

  // A low request while released must pull the output low at the very next edge.
  chk_pulse_steps: assert property (@(posedge clock) disable iff (rst)
    seq_req_low_released |=> seq_driven_hold)
    else $error("Reset pulse did not start at the next edge.");

  // The last tick of the interval must release the output at the next edge, not later.
  chk_release_steps: assert property (@(posedge clock) disable iff (rst)
    seq_last_tick |=> seq_released)
    else $error("Output not released after the last tick.");

  // The counter never runs past the end of the interval.
  chk_count_bound: assert property (@(posedge clock) disable iff (rst)
    count <= COUNT_W'(STRETCH - 1))
    else $error("Interval counter ran past its end.");

  // Without a tick the counter must hold, so only primary output cycles are counted.
  chk_count_hold: assert property (@(posedge clock) disable iff (rst)
    (state == PLRS_COUNT && req_s2 && !req_rise && !q_tick) |=> count == $past(count))
    else $error("Counter moved without a tick.");

  // A request returning high after a hold starts counting from zero.
  chk_hold_exit: assert property (@(posedge clock) disable iff (rst)
    (state == PLRS_HOLD && req_s2) |=> state == PLRS_COUNT && count == '0)
    else $error("Counting did not restart when the request rose.");

  // Lock with the request high starts the interval from zero.
  chk_lock_start: assert property (@(posedge clock) disable iff (rst)
    (state == PLRS_WAIT && lock_s2 && req_s2) |=> state == PLRS_COUNT && count == '0)
    else $error("Interval did not start on lock.");

  // Lock lost while released pulls the output low again; the indicator must not lie.
  chk_lock_loss: assert property (@(posedge clock) disable iff (rst)
    (state == PLRS_IDLE && req_s2 && !lock_s2) |=> state == PLRS_WAIT && reset_out_oe)
    else $error("Output stayed released after lock was lost.");

endmodule

`default_nettype wire

// File: bench/plrs_cpu_model.sv
// Processor-side model that pulls up the reset wire and issues reset requests.
`timescale 1ns/1ps
`default_nettype none
module plrs_cpu_model (
  input  wire logic clock,
  input  wire logic oe,
  input  wire logic o,
  input  wire logic hold_low,
  input  wire logic pulse,
  output wire logic pin,
  output var  logic reset_req_n = 1'b1
);
  // The pull-up wins whenever the stretcher stops driving.
  assign pin = oe ? o : 1'b1;
  // A pulse is only passed on once the wire is high, so pulses never overlap start-up; hold_low is passed on at any time.
  always @(negedge clock) begin
    reset_req_n <= !(hold_low || (pulse && pin));
  end
endmodule
`default_nettype wire

// File: bench/plrs_stretcher_tb.sv
// Self-checking testbench of the lock and reset stretcher.
`timescale 1ns/1ps
`default_nettype none
module plrs_stretcher_tb;
  import plrs_pkg::*;
  localparam int unsigned ST = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic q_tick = 1'b0;
  logic lock = 1'b0;
  logic hold_low = 1'b0;
  logic pulse = 1'b0;
  logic req_n, oe, o, rel, pin;
  int   num_errors = 0;
  int   checks = 0;

  always #2 clock = !clock;
  // A tick every other cycle stands in for the primary output clock.
  always @(negedge clock) q_tick <= !q_tick;

  plrs_stretcher #(.STRETCH(ST)) uut (.clock(clock), .rst(rst), .q_tick(q_tick), .pll_locked(lock),
    .reset_req_n(req_n), .reset_out_oe(oe), .reset_out_o(o), .lock_released(rel));
  plrs_cpu_model cpu (.clock(clock), .oe(oe), .o(o), .hold_low(hold_low), .pulse(pulse),
    .pin(pin), .reset_req_n(req_n));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic lk, input logic hl);
    @(negedge clock);
    rst = 1'b1;
    lock = lk;
    hold_low <= hl;
    repeat (6) @(negedge clock);
    rst = 1'b0;
  endtask

  // Counts ticks until release; sync latency may cost up to two ticks.
  task automatic wait_rel();
    int n;
    n = 0;
    for (int i = 0; i < 200 && rel !== 1'b1; i++) begin
      @(negedge clock);
      n += int'(q_tick);
    end
    cmp({31'h0, n >= ST && n <= ST + 2}, 32'h1);
    cmp({31'h0, pin}, 32'h1);
  endtask

  task automatic t_power();
    do_reset(1'b0, 1'b0);
    repeat (30) @(negedge clock);
    cmp({31'h0, pin}, 32'h0);
    lock = 1'b1;
    wait_rel();
    $display("power-up test done");
  endtask

  task automatic t_pulse();
    pulse <= 1'b1;
    repeat (4) @(negedge clock);
    pulse <= 1'b0;
    cmp({31'h0, oe}, 32'h1);
    repeat (2) @(negedge clock);
    wait_rel();
    $display("pulse test done");
  endtask

  // Lock lost while released must pull the pin low again until a fresh interval after relock.
  task automatic t_relock();
    lock = 1'b0;
    repeat (6) @(negedge clock);
    cmp({31'h0, pin}, 32'h0);
    lock = 1'b1;
    wait_rel();
    $display("lock loss test done");
  endtask

  task automatic t_hold();
    do_reset(1'b1, 1'b1);
    repeat (40) @(negedge clock);
    cmp({31'h0, oe}, 32'h1);
    hold_low <= 1'b0;
    repeat (2) @(negedge clock);
    wait_rel();
    $display("held start-up test done");
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #20000;
    num_errors++;
    final_report();
  end

  initial begin
    t_power();
    t_pulse();
    t_relock();
    t_hold();
    final_report();
  end
endmodule
`default_nettype wire
